// ===== verilog/dpf_pkg.sv
// Purpose: Shared constants, types and decode functions for the dedicated pin control block.
// Assumes: One core clock; per-pin configuration arrives as flat vectors.
// Notes: Pin index 0..4 are the trace/fast SPI pins, 5..10 quad SPI, 11..12 two-wire.
`default_nettype none
package dpf_pkg;
  localparam int NPIN = 13;
  localparam int NSPIM = 5;
  localparam int NQSPI = 6;
  localparam int NTWI = 2;
  localparam int SPIM_LO = 0;
  localparam int QSPI_LO = 5;
  localparam int TWI_LO = 11;
  localparam int DRV_W = 4;
  localparam int SEL_W = 2;
  localparam int SPIM_MISO_IDX = 2;
  // Drive field codes of the per-pin configuration.
  localparam logic [3:0] DRV_STANDARD = 4'h0;
  localparam logic [3:0] DRV_HIGH = 4'h3;
  localparam logic [3:0] DRV_EXTRA_HIGH = 4'hB;
  // Core/peripheral select field codes.
  localparam logic [1:0] SEL_APP_CORE = 2'h0;
  localparam logic [1:0] SEL_NET_CORE = 2'h1;
  localparam logic [1:0] SEL_PERIPH = 2'h2;
  localparam logic [1:0] SEL_TRACE = 2'h3;
  localparam logic [NPIN-1:0] PIN_RESET = 13'h0000;
  localparam logic [NPIN-1:0] OE_N_RESET = 13'h1FFF;

  typedef enum logic [1:0] {FEM_SLEEP, FEM_TX, FEM_RX, FEM_BYPASS} dpf_fem_state_t;

  typedef struct packed {
    logic [NPIN-1:0] in_s1;
    logic [NPIN-1:0] in_s2;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe_n;
    logic [NPIN-1:0] high_drv;
    logic [NPIN-1:0] extra_drv;
    logic [NPIN-1:0] open_drain;
    logic [NPIN-1:0] unsupported;
    logic [NTWI-1:0] twi_in;
    logic [NQSPI-1:0] qspi_in;
    logic miso_in;
    logic spim_dedicated;
    logic variant_s1;
    logic variant_s2;
  } dpf_pin_st_t;

  typedef struct packed {
    dpf_fem_state_t state;
    logic pa_en;
    logic lna_en;
    logic pa_oe_n;
    logic lna_oe_n;
  } dpf_fem_st_t;

  function automatic logic is_extra(input logic [3:0] drv);
    return drv == DRV_EXTRA_HIGH;
  endfunction

  function automatic logic is_high(input logic [3:0] drv);
    return drv == DRV_HIGH;
  endfunction

  // Returns {lna_enable, pa_enable} for a front-end state.
  function automatic logic [1:0] fem_lines(input dpf_fem_state_t st);
    case (st)
      FEM_TX: return 2'h1;
      FEM_RX: return 2'h2;
      FEM_BYPASS: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== verilog/dpf_fem.sv
// Purpose: Front-end amplifier control lines, registered so both change on one edge.
// Assumes: The variant flag is already synchronised to the core clock.
// Notes: Without the front-end variant the two lines act as ordinary GPIO.
`default_nettype none
module dpf_fem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic variant,
  input wire logic [1:0] req_state,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic pa_en,
  output logic lna_en,
  output logic pa_oe_n,
  output logic lna_oe_n,
  output logic [1:0] state
);
  dpf_pkg::dpf_fem_st_t r;
  dpf_pkg::dpf_fem_st_t next_r;

  always_comb begin
    next_r = r;
    if (variant) begin
      // Lines are reserved for the front-end and always driven.
      next_r.state = dpf_pkg::dpf_fem_state_t'(req_state);
      {next_r.lna_en, next_r.pa_en} = dpf_pkg::fem_lines(next_r.state);
      next_r.pa_oe_n = 1'b0;
      next_r.lna_oe_n = 1'b0;
    end else begin
      next_r.state = dpf_pkg::FEM_SLEEP;
      next_r.pa_en = gpio_out[0];
      next_r.lna_en = gpio_out[1];
      next_r.pa_oe_n = ~gpio_oe[0];
      next_r.lna_oe_n = ~gpio_oe[1];
    end
  end

  // Both lines leave the same flop bank, so no mixed combination can appear mid-change.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.state <= dpf_pkg::FEM_SLEEP;
      r.pa_en <= 1'b0;
      r.lna_en <= 1'b0;
      r.pa_oe_n <= 1'b0;
      r.lna_oe_n <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign pa_en = r.pa_en;
  assign lna_en = r.lna_en;
  assign pa_oe_n = r.pa_oe_n;
  assign lna_oe_n = r.lna_oe_n;
  assign state = r.state;

  chk_fem_state_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(variant) |-> (pa_en == ($past(req_state) == 2'h1 || $past(req_state) == 2'h3)
      && lna_en == ($past(req_state) == 2'h2 || $past(req_state) == 2'h3)))
    else $error("Front-end lines do not match the requested state.");

  chk_fem_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    $past(variant) |-> !pa_oe_n && !lna_oe_n)
    else $error("Front-end lines not driven on the front-end variant.");

  chk_fem_reset_sleep: assert property (@(posedge clk)
    $rose(rst_n) |-> !pa_en && !lna_en && state == 2'h0)
    else $error("Front-end not in sleep after reset.");

  chk_fem_one_edge: assert property (@(posedge clk) disable iff (!rst_n)
    variant && $stable(req_state) && $past(variant) ##1 variant |-> $stable({pa_en, lna_en}))
    else $error("Front-end lines moved without a new request.");
endmodule
`default_nettype wire

// ===== verilog/dpf_pinmux.sv
// Purpose: Routes fast peripherals onto their dedicated pins and sets each pin's drive.
// Assumes: Configuration vectors are static or change on the core clock.
// Notes: Pin inputs pass two flops before use; all outputs are registered.
`default_nettype none
// What this block does
// - Extra-high drive on the two-wire pins enables the 20 mA open-drain driver.
// - Quad SPI runs only on port 0 pins 13-18, given via peripheral select.
// - Peripheral select on fast SPI pins overrides its pin-select, using dedicated pins.
// - On the front-end variant, port 1 pins 8 and 9 are amplifier enables.
// - Enable lines decode: both low sleep, PA transmit, LNA receive, both bypass.
// - With GPIOs at reset default, front-end sits in sleep.
module dpf_pinmux (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [51:0] CFG_DRIVE,
  input wire logic [25:0] CFG_SEL,
  input wire logic [12:0] GPIO_OUT,
  input wire logic [12:0] GPIO_OE,
  input wire logic [12:0] PIN_IN,
  input wire logic [4:0] SPIM_OUT,
  input wire logic [4:0] SPIM_OE,
  input wire logic [5:0] QSPI_OUT,
  input wire logic [5:0] QSPI_OE,
  input wire logic TWI_PSEL_FAST,
  input wire logic [1:0] TWI_OUT,
  input wire logic [3:0] TRACE_DATA,
  input wire logic TRACE_CLK,
  input wire logic FEM_VARIANT,
  input wire logic [1:0] FEM_REQ,
  input wire logic [1:0] FEM_GPIO_OUT,
  input wire logic [1:0] FEM_GPIO_OE,
  output logic [12:0] PIN_OUT,
  output logic [12:0] PIN_OE_N,
  output logic [12:0] PIN_HIGH_DRIVE,
  output logic [12:0] PIN_EXTRA_DRIVE,
  output logic [12:0] PIN_OPEN_DRAIN,
  output logic [12:0] PIN_DRIVE_UNSUPPORTED,
  output logic [1:0] TWI_IN,
  output logic [5:0] QSPI_IN,
  output logic SPIM_MISO_IN,
  output logic SPIM_DEDICATED,
  output logic POWER_AMP_ENABLE_LINE,
  output logic LOW_NOISE_AMP_ENABLE_LINE,
  output logic POWER_AMP_OE_N,
  output logic LOW_NOISE_AMP_OE_N,
  output logic [1:0] FEM_STATE
);
  dpf_pkg::dpf_pin_st_t r;
  dpf_pkg::dpf_pin_st_t next_r;
  logic [4:0] trace_vec;

  // Pin 0 carries trace data bit 3 and pin 4 the trace clock.
  assign trace_vec = {TRACE_CLK, TRACE_DATA[0], TRACE_DATA[1], TRACE_DATA[2], TRACE_DATA[3]};

  always_comb begin
    logic [3:0] drv;
    logic [1:0] sel;
    logic all_periph;
    drv = dpf_pkg::DRV_STANDARD;
    sel = dpf_pkg::SEL_APP_CORE;
    all_periph = 1'b1;
    next_r = r;
    next_r.in_s1 = PIN_IN;
    next_r.in_s2 = r.in_s1;
    next_r.variant_s1 = FEM_VARIANT;
    next_r.variant_s2 = r.variant_s1;
    for (int i = 0; i < dpf_pkg::NPIN; i++) begin
      drv = CFG_DRIVE[i*dpf_pkg::DRV_W +: dpf_pkg::DRV_W];
      next_r.pin_out[i] = GPIO_OUT[i];
      next_r.pin_oe_n[i] = ~GPIO_OE[i];
      next_r.high_drv[i] = dpf_pkg::is_high(drv);
      // Quad SPI pins have no extra-high driver; the request is flagged and dropped.
      if (i >= dpf_pkg::QSPI_LO && i < dpf_pkg::TWI_LO) begin
        next_r.extra_drv[i] = 1'b0;
        next_r.unsupported[i] = dpf_pkg::is_extra(drv);
      end else begin
        next_r.extra_drv[i] = dpf_pkg::is_extra(drv);
        next_r.unsupported[i] = 1'b0;
      end
      next_r.open_drain[i] = (i >= dpf_pkg::TWI_LO) && dpf_pkg::is_extra(drv);
    end
    for (int i = 0; i < dpf_pkg::NSPIM; i++) begin
      sel = CFG_SEL[(dpf_pkg::SPIM_LO + i)*dpf_pkg::SEL_W +: dpf_pkg::SEL_W];
      if (sel != dpf_pkg::SEL_PERIPH) begin
        all_periph = 1'b0;
      end
      if (sel == dpf_pkg::SEL_PERIPH) begin
        next_r.pin_out[dpf_pkg::SPIM_LO + i] = SPIM_OUT[i];
        next_r.pin_oe_n[dpf_pkg::SPIM_LO + i] = ~SPIM_OE[i];
      end else if (sel == dpf_pkg::SEL_TRACE) begin
        next_r.pin_out[dpf_pkg::SPIM_LO + i] = trace_vec[i];
        next_r.pin_oe_n[dpf_pkg::SPIM_LO + i] = 1'b0;
      end
    end
    next_r.spim_dedicated = all_periph;
    for (int i = 0; i < dpf_pkg::NQSPI; i++) begin
      sel = CFG_SEL[(dpf_pkg::QSPI_LO + i)*dpf_pkg::SEL_W +: dpf_pkg::SEL_W];
      if (sel == dpf_pkg::SEL_PERIPH) begin
        next_r.pin_out[dpf_pkg::QSPI_LO + i] = QSPI_OUT[i];
        next_r.pin_oe_n[dpf_pkg::QSPI_LO + i] = ~QSPI_OE[i];
      end
    end
    for (int i = 0; i < dpf_pkg::NTWI; i++) begin
      // With TWI_PSEL_FAST set, two-wire pins only pull low; a one releases the line.
      if (TWI_PSEL_FAST) begin
        next_r.pin_out[dpf_pkg::TWI_LO + i] = 1'b0;
        next_r.pin_oe_n[dpf_pkg::TWI_LO + i] = TWI_OUT[i];
      end
    end
    next_r.twi_in = r.in_s2[dpf_pkg::TWI_LO +: dpf_pkg::NTWI];
    next_r.qspi_in = r.in_s2[dpf_pkg::QSPI_LO +: dpf_pkg::NQSPI];
    next_r.miso_in = r.in_s2[dpf_pkg::SPIM_LO + dpf_pkg::SPIM_MISO_IDX];
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.pin_oe_n <= dpf_pkg::OE_N_RESET;
      r.in_s1 <= dpf_pkg::PIN_RESET;
    end else begin
      r <= next_r;
    end
  end

  dpf_fem u_fem (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .variant(r.variant_s2),
    .req_state(FEM_REQ),
    .gpio_out(FEM_GPIO_OUT),
    .gpio_oe(FEM_GPIO_OE),
    .pa_en(POWER_AMP_ENABLE_LINE),
    .lna_en(LOW_NOISE_AMP_ENABLE_LINE),
    .pa_oe_n(POWER_AMP_OE_N),
    .lna_oe_n(LOW_NOISE_AMP_OE_N),
    .state(FEM_STATE)
  );

  assign PIN_OUT = r.pin_out;
  assign PIN_OE_N = r.pin_oe_n;
  assign PIN_HIGH_DRIVE = r.high_drv;
  assign PIN_EXTRA_DRIVE = r.extra_drv;
  assign PIN_OPEN_DRAIN = r.open_drain;
  assign PIN_DRIVE_UNSUPPORTED = r.unsupported;
  assign TWI_IN = r.twi_in;
  assign QSPI_IN = r.qspi_in;
  assign SPIM_MISO_IN = r.miso_in;
  assign SPIM_DEDICATED = r.spim_dedicated;

  chk_twi_open_drain: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CFG_DRIVE[51:48] == dpf_pkg::DRV_EXTRA_HIGH |=> PIN_OPEN_DRAIN[12] && PIN_EXTRA_DRIVE[12])
    else $error("Two-wire pin lacks the open-drain extra-high driver.");

  chk_qspi_route: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CFG_SEL[11:10] == dpf_pkg::SEL_PERIPH |=> PIN_OUT[5] == $past(QSPI_OUT[0])
      && PIN_OE_N[5] == !$past(QSPI_OE[0]))
    else $error("Quad SPI data 0 not routed to its dedicated pin.");

  chk_spim_dedicated: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CFG_SEL[9:0] == 10'h2AA |=> SPIM_DEDICATED && PIN_OUT[4:0] == $past(SPIM_OUT))
    else $error("Fast SPI master not on its dedicated pins.");

  chk_qspi_no_extra: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CFG_DRIVE[23:20] == dpf_pkg::DRV_EXTRA_HIGH |=> !PIN_EXTRA_DRIVE[5] && PIN_DRIVE_UNSUPPORTED[5])
    else $error("Extra-high drive enabled on a quad SPI pin.");
endmodule
`default_nettype wire

// ===== sim/dpf_fem_model.sv
// Purpose: Behavioural front-end amplifier that decodes its two enable lines into a mode.
// Assumes: A released line reads low, like the part's own pull-down.
// Notes: The mode changes only after the settling delay, so early sampling shows stale state.
`default_nettype none
module dpf_fem_model #(
  parameter int SETTLE_NS = 300
) (
  input wire logic pa_line,
  input wire logic lna_line,
  input wire logic pa_oe_n,
  input wire logic lna_oe_n,
  output logic [1:0] mode
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic pa = !pa_oe_n && pa_line;
  wire logic lna = !lna_oe_n && lna_line;
  // One process owns the mode, so it starts in sleep and then follows the lines.
  // Transport delay keeps every change, so a glitch on the lines would show up here.
  initial begin
    mode = 2'h0;
    forever begin
      @(pa or lna);
      mode <= #(SETTLE_NS) {lna, pa};
    end
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the dedicated pin and front-end control block.
// Assumes: Inputs change on the falling edge; results are compared at the falling edge.
// Notes: Each note holds an output group, a mask and the expected masked value.
`default_nettype none
`define CHK(W, E, O) begin checks++; if ((O) !== (E)) begin bad_count++; \
  $display("ERROR group %0d expected %h seen %h", W, E, O); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int sel; logic [15:0] mask; logic [15:0] exp;} dpf_note_t;
  dpf_note_t notes[$];
  dpf_note_t n;
  int checks = 0, bad_count = 0, cycles = 0;
  logic [31:0] r;
  logic CORE_CLK = 0, RESET_N = 0, TWI_PSEL_FAST = 0, TRACE_CLK = 0, FEM_VARIANT = 0;
  logic [51:0] CFG_DRIVE = '0;
  logic [25:0] CFG_SEL = '0;
  logic [12:0] GPIO_OUT = '0, GPIO_OE = '0, PIN_IN = '0;
  logic [4:0] SPIM_OUT = '0, SPIM_OE = '0;
  logic [5:0] QSPI_OUT = '0, QSPI_OE = '0;
  logic [3:0] TRACE_DATA = '0;
  logic [1:0] TWI_OUT = '0, FEM_REQ = '0, FEM_GPIO_OUT = '0, FEM_GPIO_OE = '0;
  logic [12:0] PIN_OUT, PIN_OE_N, PIN_HIGH_DRIVE, PIN_EXTRA_DRIVE, PIN_OPEN_DRAIN, PIN_UNSUP;
  logic [1:0] TWI_IN, FEM_STATE, fem_mode;
  logic [5:0] QSPI_IN;
  logic SPIM_MISO_IN, SPIM_DEDICATED, PA_LINE, LNA_LINE, PA_OE_N, LNA_OE_N;
  always #5 CORE_CLK = ~CORE_CLK;
  dpf_pinmux dpf_pinmux_i (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CFG_DRIVE(CFG_DRIVE),
    .CFG_SEL(CFG_SEL), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .PIN_IN(PIN_IN),
    .SPIM_OUT(SPIM_OUT), .SPIM_OE(SPIM_OE), .QSPI_OUT(QSPI_OUT), .QSPI_OE(QSPI_OE),
    .TWI_PSEL_FAST(TWI_PSEL_FAST), .TWI_OUT(TWI_OUT), .TRACE_DATA(TRACE_DATA),
    .TRACE_CLK(TRACE_CLK), .FEM_VARIANT(FEM_VARIANT), .FEM_REQ(FEM_REQ),
    .FEM_GPIO_OUT(FEM_GPIO_OUT), .FEM_GPIO_OE(FEM_GPIO_OE), .PIN_OUT(PIN_OUT),
    .PIN_OE_N(PIN_OE_N), .PIN_HIGH_DRIVE(PIN_HIGH_DRIVE), .PIN_EXTRA_DRIVE(PIN_EXTRA_DRIVE),
    .PIN_OPEN_DRAIN(PIN_OPEN_DRAIN), .PIN_DRIVE_UNSUPPORTED(PIN_UNSUP), .TWI_IN(TWI_IN),
    .QSPI_IN(QSPI_IN), .SPIM_MISO_IN(SPIM_MISO_IN), .SPIM_DEDICATED(SPIM_DEDICATED),
    .POWER_AMP_ENABLE_LINE(PA_LINE), .LOW_NOISE_AMP_ENABLE_LINE(LNA_LINE),
    .POWER_AMP_OE_N(PA_OE_N), .LOW_NOISE_AMP_OE_N(LNA_OE_N), .FEM_STATE(FEM_STATE));
  dpf_fem_model dpf_fem_model_i (.pa_line(PA_LINE), .lna_line(LNA_LINE), .pa_oe_n(PA_OE_N),
    .lna_oe_n(LNA_OE_N), .mode(fem_mode));
  function automatic logic [15:0] pick(input int s);
    case (s)
      0: return 16'(PIN_OUT);
      1: return 16'(PIN_OE_N);
      2: return 16'(PIN_HIGH_DRIVE);
      3: return 16'(PIN_EXTRA_DRIVE);
      4: return 16'(PIN_OPEN_DRAIN);
      5: return 16'(PIN_UNSUP);
      6: return 16'(TWI_IN);
      7: return 16'(QSPI_IN);
      8: return 16'({SPIM_DEDICATED, SPIM_MISO_IN});
      default: return 16'({fem_mode, FEM_STATE, LNA_OE_N, PA_OE_N, LNA_LINE, PA_LINE});
    endcase
  endfunction
  task automatic note(input int s, input logic [15:0] m, input logic [15:0] e);
    notes.push_back('{s, m, e});
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge CORE_CLK) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      `CHK(n.sel, n.exp, pick(n.sel) & n.mask)
    end
  end
  // A hang is cut short well beyond the two hundred or so cycles the sequence needs.
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    void'($urandom(32'hA4BB));
    step(5);
    note(1, 16'h1FFF, 16'h1FFF);
    note(9, 16'h3F, 16'h00);
    step(1);
    @(negedge CORE_CLK) RESET_N = 1;
    step(3);
    note(9, 16'hC3, 16'h00);
    note(3, 16'h1FFF, 16'h0000);
    note(4, 16'h1FFF, 16'h0000);
    @(negedge CORE_CLK) FEM_VARIANT = 1;
    step(3);
    for (int q = 0; q < 4; q++) begin
      @(negedge CORE_CLK) FEM_REQ = 2'(q);
      step(1);
      note(9, 16'h3F, 16'({2'(q), 2'b00, 2'(q)}));
      step(40);
      note(9, 16'hC0, 16'({2'(q), 6'h00}));
    end
    r = $urandom;
    @(negedge CORE_CLK) {FEM_VARIANT, FEM_GPIO_OE, FEM_GPIO_OUT} = {3'b011, r[1:0]};
    step(3);
    note(9, 16'h3F, 16'({4'h0, r[1:0]}));
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      @(negedge CORE_CLK);
      CFG_SEL = {4'h0, {11{2'h2}}};
      CFG_DRIVE = {8'hBB, {11{4'h3}}};
      {TWI_PSEL_FAST, SPIM_OE, GPIO_OUT} = {1'b1, 5'h1F, r[12:0]};
      {TWI_OUT, QSPI_OUT, QSPI_OE, SPIM_OUT, PIN_IN} = {r[1:0], r[7:2], r[13:8], r[18:14], r[31:19]};
      step(1);
      note(0, 16'h1FFF, 16'({2'b00, r[7:2], r[18:14]}));
      note(1, 16'h1FFF, 16'({r[1:0], ~r[13:8], 5'h00}));
      note(2, 16'h07FF, 16'h07FF);
      note(3, 16'h1FFF, 16'h1800);
      note(4, 16'h1FFF, 16'h1800);
      note(5, 16'h1FFF, 16'h0000);
      note(8, 16'h2, 16'h2);
      step(2);
      note(6, 16'h3, 16'(r[31:30]));
      note(7, 16'h3F, 16'(r[29:24]));
      note(8, 16'h1, 16'(r[21]));
    end
    @(negedge CORE_CLK) {CFG_DRIVE[43:20], CFG_SEL[1:0]} = {24'hBBBBBB, 2'h1};
    step(1);
    note(0, 16'h0001, 16'(r[0]));
    note(1, 16'h0001, 16'h0001);
    note(3, 16'h07E0, 16'h0000);
    note(5, 16'h1FFF, 16'h07E0);
    note(8, 16'h2, 16'h0);
    r = $urandom;
    @(negedge CORE_CLK) {CFG_SEL[9:0], CFG_DRIVE[19:0]} = {{5{2'h3}}, 20'hBBBBB};
    {TRACE_CLK, TRACE_DATA} = r[4:0];
    {TWI_PSEL_FAST, GPIO_OE, GPIO_OUT} = {1'b0, r[17:5], r[30:18]};
    step(1);
    note(0, 16'h1800, 16'({r[30:29], 11'h000}));
    note(1, 16'h1800, 16'({~r[17:16], 11'h000}));
    note(0, 16'h1F, 16'({r[4], r[0], r[1], r[2], r[3]}));
    note(1, 16'h1F, 16'h00);
    note(3, 16'h1F, 16'h1F);
    step(1);
    @(negedge CORE_CLK) RESET_N = 0;
    step(1);
    note(1, 16'h1FFF, 16'h1FFF);
    note(9, 16'h3F, 16'h00);
    step(1);
    @(negedge CORE_CLK) RESET_N = 1;
    step(2);
    results();
  end
endmodule
`default_nettype wire
